// >>> src/mpmc_pkg.sv
// Shared constants and types for the metering pin mode control block
package mpmc_pkg;

  // ------------------------------------------------------------------
  // Timing of the serial mode entry window (in master-clock periods)
  // ------------------------------------------------------------------
  localparam int unsigned WINSET_MCLK   = 1;
  localparam int unsigned WINDOW_MCLK   = 8;
  localparam int unsigned CYC_PER_MCLK  = 1;
  localparam logic [3:0]  WIN_START_CYC = 4'(WINSET_MCLK * CYC_PER_MCLK);
  localparam logic [3:0]  WIN_END_CYC   = 4'(WINDOW_MCLK * CYC_PER_MCLK);

  // ------------------------------------------------------------------
  // Entry code and data widths
  // ------------------------------------------------------------------
  localparam int unsigned ENTRY_BITS    = 4;
  // Arbitrary neutral entry code value
  localparam logic [3:0]  ENTRY_CODE    = 4'hA;
  localparam int unsigned WORD_W        = 16;
  localparam logic [15:0] ZERO_WORD     = 16'h0000;

  // ------------------------------------------------------------------
  // Current channel gain codes and factors
  // ------------------------------------------------------------------
  localparam logic [1:0]  GAIN_CODE_X1  = 2'h0;
  localparam logic [1:0]  GAIN_CODE_X2  = 2'h1;
  localparam logic [1:0]  GAIN_CODE_X8  = 2'h2;
  localparam logic [1:0]  GAIN_CODE_X16 = 2'h3;
  localparam logic [4:0]  GAIN_X1       = 5'h01;
  localparam logic [4:0]  GAIN_X2       = 5'h02;
  localparam logic [4:0]  GAIN_X8       = 5'h08;
  localparam logic [4:0]  GAIN_X16      = 5'h10;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [2:0]  FREQ_SEL_RST  = 3'h0;
  localparam logic [4:0]  GAIN_RST      = 5'h01;

  // ------------------------------------------------------------------
  // Serial mode entry states
  // ------------------------------------------------------------------
  typedef enum logic [1:0] {
    MPMC_ST_CLEAR,
    MPMC_ST_WINDOW,
    MPMC_ST_PULSE,
    MPMC_ST_SERIAL
  } mpmc_entry_st_t;

endpackage

// >>> src/mpmc_neg_flag.sv
// Negative power indicator updated on the calibration pulse rising edge
`timescale 1ns/100ps
`default_nettype none
module mpmc_neg_flag (
  input  wire logic core_clk,
  input  wire logic clr,
  input  wire logic calib_pulse,
  input  wire logic power_negative,
  output logic      neg_flag_q
);

  logic calib_prev_q;
  wire  calib_rise = calib_pulse & ~calib_prev_q;

  // ------------------------------------------------------------------
  // Edge tracking
  // ------------------------------------------------------------------
  // Flag only moves on a calibration edge, so it stays set until
  // positive power is seen together with a new pulse
  always_ff @(posedge core_clk) begin
    if (clr) begin
      calib_prev_q <= 1'b0;
      neg_flag_q   <= 1'b0;
    end else begin
      calib_prev_q <= calib_pulse;
      if (calib_rise) begin
        neg_flag_q <= power_negative;
      end
    end
  end

endmodule
`default_nettype wire

// >>> src/mpmc_entry_detect.sv
// Serial mode entry window and code detector
`timescale 1ns/100ps
`default_nettype none
module mpmc_entry_detect #(
  parameter int unsigned         CODE_BITS = mpmc_pkg::ENTRY_BITS,
  parameter logic [CODE_BITS-1:0] CODE     = mpmc_pkg::ENTRY_CODE
) (
  input  wire logic core_clk,
  input  wire logic clr,
  input  wire logic sck_pin,
  input  wire logic sdi_pin,
  input  wire logic cs_n_pin,
  output logic      serial_mode_q
);

  mpmc_pkg::mpmc_entry_st_t state_q;
  mpmc_pkg::mpmc_entry_st_t state_d;
  logic [3:0]           win_cnt_q;
  logic [CODE_BITS-1:0] code_q;
  logic [3:0]           bits_q;
  logic                 sck_prev_q;

  // ------------------------------------------------------------------
  // Window decode
  // ------------------------------------------------------------------
  wire sck_rise  = sck_pin & ~sck_prev_q;
  wire in_window = (win_cnt_q >= mpmc_pkg::WIN_START_CYC)
                 & (win_cnt_q <= mpmc_pkg::WIN_END_CYC);
  wire take_bit  = (state_q == mpmc_pkg::MPMC_ST_WINDOW) & in_window
                 & sck_rise & ~cs_n_pin;
  wire win_over  = win_cnt_q > mpmc_pkg::WIN_END_CYC;
  wire code_ok   = (bits_q == 4'(CODE_BITS)) & (code_q == CODE);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      mpmc_pkg::MPMC_ST_CLEAR:  state_d = mpmc_pkg::MPMC_ST_WINDOW;
      mpmc_pkg::MPMC_ST_WINDOW: if (win_over) begin
        state_d = code_ok ? mpmc_pkg::MPMC_ST_SERIAL : mpmc_pkg::MPMC_ST_PULSE;
      end
      mpmc_pkg::MPMC_ST_PULSE:  state_d = mpmc_pkg::MPMC_ST_PULSE;
      mpmc_pkg::MPMC_ST_SERIAL: state_d = mpmc_pkg::MPMC_ST_SERIAL;
    endcase
  end

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Bits outside the window are ignored; a late host stays in pulse mode
  always_ff @(posedge core_clk) begin
    if (clr) begin
      state_q       <= mpmc_pkg::MPMC_ST_CLEAR;
      win_cnt_q     <= 4'h0;
      code_q        <= '0;
      bits_q        <= 4'h0;
      sck_prev_q    <= 1'b0;
      serial_mode_q <= 1'b0;
    end else begin
      state_q    <= state_d;
      sck_prev_q <= sck_pin;
      if (!win_over) begin
        win_cnt_q <= win_cnt_q + 4'h1;
      end
      if (take_bit && bits_q < 4'(CODE_BITS)) begin
        code_q <= {code_q[CODE_BITS-2:0], sdi_pin};
        bits_q <= bits_q + 4'h1;
      end
      serial_mode_q <= (state_d == mpmc_pkg::MPMC_ST_SERIAL);
    end
  end

endmodule
`default_nettype wire

// >>> src/mpmc_pin_mode.sv
// Pin mode and control logic of the metering device
//
// Overview of operation
// - A high filter-control input enables the offset filter in both channels.
// - A low filter-control input bypasses the offset filter so DC passes.
// - Chip clear resets converters, registers, decimators and accumulators.
// - While chip clear is low all registers and both converters stay in reset.
// - During chip clear each converter output word is forced to zero.
// - Chip clear is also the way the host enters serial interface mode.
// - The clock pin is serial clock in serial mode, else frequency select 2.
// - The data-in pin is serial data in serial mode, else frequency select 1.
// - The select pin is chip select in serial mode, else frequency select 0.
// - The shared output is serial data out in serial mode, else negative flag.
// - The negative flag follows power sign at each calibration pulse rising edge.
// - Two inputs select the current channel amplifier gain.
// - Gain codes 00, 01, 10 and 11 give gains 1, 2, 8 and 16.
// - Two counter pulse outputs and one calibration pulse output are driven.
`timescale 1ns/100ps
`default_nettype none
module mpmc_pin_mode #(
  parameter int unsigned W = mpmc_pkg::WORD_W
) (
  input  wire logic         core_clk,
  input  wire logic         srst,
  input  wire logic         chip_clear_n,
  input  wire logic         offset_filter_ctrl,
  input  wire logic         gain_sel_hi,
  input  wire logic         gain_sel_lo,
  input  wire logic         freq_range_sel_2,
  input  wire logic         freq_range_sel_1,
  input  wire logic         freq_range_sel_0,
  input  wire logic [W-1:0] current_channel_word,
  input  wire logic [W-1:0] voltage_channel_word,
  input  wire logic         power_negative,
  input  wire logic         slow_pulse_a,
  input  wire logic         slow_pulse_b,
  input  wire logic         fast_pulse,
  output logic              offset_filter_en_q,
  output logic              conv_reset_q,
  output logic [W-1:0]      current_word_q,
  output logic [W-1:0]      voltage_word_q,
  output logic [4:0]        current_gain_amp_q,
  output logic [2:0]        slow_rate_constant_q,
  output logic [2:0]        fast_rate_constant_q,
  output logic              serial_mode_q,
  output logic              negative_power_flag,
  output logic              counter_pulse_a,
  output logic              counter_pulse_b,
  output logic              calib_pulse_out
);

  // ------------------------------------------------------------------
  // Reset and mode decode
  // ------------------------------------------------------------------
  wire clr = srst | ~chip_clear_n;

  logic neg_flag;
  logic serial_mode;

  // Shared pin aliases in serial mode
  wire spi_sck  = freq_range_sel_2;
  wire spi_sdi  = freq_range_sel_1;
  wire spi_cs_n = freq_range_sel_0;

  mpmc_entry_detect u_entry (
    .core_clk      (core_clk),
    .clr           (clr),
    .sck_pin       (spi_sck),
    .sdi_pin       (spi_sdi),
    .cs_n_pin      (spi_cs_n),
    .serial_mode_q (serial_mode)
  );

  mpmc_neg_flag u_neg (
    .core_clk       (core_clk),
    .clr            (clr),
    .calib_pulse    (fast_pulse),
    .power_negative (power_negative),
    .neg_flag_q     (neg_flag)
  );

  // ------------------------------------------------------------------
  // Gain decode
  // ------------------------------------------------------------------
  wire [1:0] gain_code = {gain_sel_hi, gain_sel_lo};
  wire [4:0] gain_dec  =
    (gain_code == mpmc_pkg::GAIN_CODE_X1) ? mpmc_pkg::GAIN_X1 :
    (gain_code == mpmc_pkg::GAIN_CODE_X2) ? mpmc_pkg::GAIN_X2 :
    (gain_code == mpmc_pkg::GAIN_CODE_X8) ? mpmc_pkg::GAIN_X8 :
                                            mpmc_pkg::GAIN_X16;

  // ------------------------------------------------------------------
  // Serial output shifter
  // ------------------------------------------------------------------
  // Current word leaves first, then voltage word, MSB first; changes on
  // the falling serial clock so the host samples on the rising edge
  logic [2*W-1:0] shift_q;
  logic           sck_prev_q;
  logic           sdo_q;
  wire            sck_fall = ~spi_sck & sck_prev_q;
  wire            shift_en = serial_mode & ~spi_cs_n & sck_fall;
  wire [2*W-1:0]  shift_ld = {current_channel_word, voltage_channel_word};
  wire [2*W-1:0]  shift_d  = spi_cs_n ? shift_ld :
                             shift_en ? {shift_q[2*W-2:0], 1'b0} : shift_q;

  // Shared output select
  wire shared_out = serial_mode ? shift_q[2*W-1] : neg_flag;

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  // Frequency selects freeze in serial mode so serial traffic after entry
  // never disturbs the pulse rate constants; entry window bits still pass
  always_ff @(posedge core_clk) begin
    if (clr) begin
      offset_filter_en_q   <= 1'b0;
      conv_reset_q         <= 1'b1;
      current_word_q       <= mpmc_pkg::ZERO_WORD;
      voltage_word_q       <= mpmc_pkg::ZERO_WORD;
      current_gain_amp_q   <= mpmc_pkg::GAIN_RST;
      slow_rate_constant_q <= mpmc_pkg::FREQ_SEL_RST;
      fast_rate_constant_q <= mpmc_pkg::FREQ_SEL_RST;
      serial_mode_q        <= 1'b0;
      shift_q              <= '0;
      sck_prev_q           <= 1'b0;
      sdo_q                <= 1'b0;
      counter_pulse_a      <= 1'b0;
      counter_pulse_b      <= 1'b0;
      calib_pulse_out      <= 1'b0;
    end else begin
      offset_filter_en_q <= offset_filter_ctrl;
      conv_reset_q       <= 1'b0;
      current_word_q     <= current_channel_word;
      voltage_word_q     <= voltage_channel_word;
      current_gain_amp_q <= gain_dec;
      if (!serial_mode) begin
        slow_rate_constant_q <= {freq_range_sel_2, freq_range_sel_1,
                                 freq_range_sel_0};
        fast_rate_constant_q <= {freq_range_sel_2, freq_range_sel_1,
                                 freq_range_sel_0};
      end
      serial_mode_q   <= serial_mode;
      shift_q         <= shift_d;
      sck_prev_q      <= spi_sck;
      sdo_q           <= shared_out;
      counter_pulse_a <= slow_pulse_a;
      counter_pulse_b <= slow_pulse_b;
      calib_pulse_out <= fast_pulse;
    end
  end

  assign negative_power_flag = sdo_q;

endmodule
`default_nettype wire

// >>> bench/mpmc_pin_mode_assertions.sv
// Checker on the pin mode block ports
`timescale 1ns/100ps
`default_nettype none
module mpmc_pin_mode_chk (
  input wire logic        core_clk,
  input wire logic        srst,
  input wire logic        chip_clear_n,
  input wire logic        offset_filter_ctrl,
  input wire logic        gain_sel_hi,
  input wire logic        gain_sel_lo,
  input wire logic        freq_range_sel_2,
  input wire logic        freq_range_sel_1,
  input wire logic        freq_range_sel_0,
  input wire logic        power_negative,
  input wire logic        slow_pulse_a,
  input wire logic        fast_pulse,
  input wire logic        offset_filter_en_q,
  input wire logic        conv_reset_q,
  input wire logic [15:0] current_word_q,
  input wire logic [4:0]  current_gain_amp_q,
  input wire logic [2:0]  slow_rate_constant_q,
  input wire logic [2:0]  fast_rate_constant_q,
  input wire logic        serial_mode_q,
  input wire logic        negative_power_flag,
  input wire logic        counter_pulse_a,
  input wire logic        calib_pulse_out
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic       live;
  logic [1:0] gs;
  logic [2:0] fs;
  logic [3:0] up_q;
  assign live = !srst && chip_clear_n;
  assign gs = {gain_sel_hi, gain_sel_lo};
  assign fs = {freq_range_sel_2, freq_range_sel_1, freq_range_sel_0};
  // Saturates so the entry window is long over before constants are judged
  always_ff @(posedge core_clk) begin
    if (!live) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  a_filter_follow: assert property (
    $past(live) |-> offset_filter_en_q == $past(offset_filter_ctrl)) else $error("filter en");
  a_gain_map: assert property (
    $past(live) |-> current_gain_amp_q == ($past(gs) == 2'h0 ? 5'h01 :
    $past(gs) == 2'h1 ? 5'h02 : $past(gs) == 2'h2 ? 5'h08 : 5'h10)) else $error("gain");
  a_clear_zero: assert property (
    !chip_clear_n |=> conv_reset_q && current_word_q == 16'h0000 &&
    current_gain_amp_q == 5'h01) else $error("clear state");
  a_const_follow: assert property (
    up_q == 4'hF && !serial_mode_q |-> slow_rate_constant_q == $past(fs) &&
    fast_rate_constant_q == $past(fs)) else $error("rate constants");
  a_serial_freeze: assert property (
    serial_mode_q && $past(serial_mode_q) |-> $stable(slow_rate_constant_q) &&
    $stable(fast_rate_constant_q)) else $error("constants moved");
  a_entry_late: assert property (
    live && up_q < 4'h9 |-> !serial_mode_q) else $error("early serial mode");
  a_pulse_delay: assert property (
    $past(live) |-> counter_pulse_a == $past(slow_pulse_a) &&
    calib_pulse_out == $past(fast_pulse)) else $error("pulse outputs");
  a_neg_track: assert property (
    live && !serial_mode_q && $rose(fast_pulse) ##1
    (live && !serial_mode_q && !$rose(fast_pulse)) [*3] |->
    negative_power_flag == $past(power_negative, 3)) else $error("negative flag");
endmodule
bind mpmc_pin_mode mpmc_pin_mode_chk mpmc_pin_mode_chk_inst (.*);
`default_nettype wire

// >>> bench/mpmc_host_model.sv
// Host model driving the strap pins and serial mode entry
`timescale 1ns/100ps
`default_nettype none
module mpmc_host_model (
  input  wire logic       core_clk,
  input  wire logic       clr_req,
  input  wire logic       entry_req,
  input  wire logic [3:0] code,
  input  wire logic [2:0] f_sel,
  output logic            clear_n,
  output logic            sck,
  output logic            sdi,
  output logic            cs_n
);
  initial {clear_n, sck, sdi, cs_n} = 4'h0;
  always @(posedge core_clk) begin
    if (entry_req) begin
      clear_n <= 1'b0;
      {sck, sdi, cs_n} <= 3'h0;
      repeat (2) @(posedge core_clk);
      clear_n <= 1'b1;
      @(posedge core_clk);
      // Bits land on window counts 2, 4, 6 and 8
      for (int i = 0; i < 8; i++) begin
        sck <= i[0];
        sdi <= code[3 - i / 2];
        @(posedge core_clk);
      end
      // Straps return before the decision edge, so the frozen constants are known
      {sck, sdi, cs_n} <= f_sel;
    end else begin
      clear_n <= !clr_req;
      {sck, sdi, cs_n} <= f_sel;
    end
  end
endmodule
`default_nettype wire

// >>> bench/tb.sv
// Self-checking testbench for the pin mode block
`timescale 1ns/100ps
`default_nettype none
module tb;
  logic        core_clk, srst, chip_clear_n, clr_req, entry_req, power_negative;
  logic        freq_range_sel_2, freq_range_sel_1, freq_range_sel_0;
  logic        offset_filter_ctrl, gain_sel_hi, gain_sel_lo;
  logic        slow_pulse_a, slow_pulse_b, fast_pulse, conv_reset_q, serial_mode_q;
  logic        offset_filter_en_q, negative_power_flag;
  logic        counter_pulse_a, counter_pulse_b, calib_pulse_out;
  logic [3:0]  code;
  logic [2:0]  f_sel, slow_rate_constant_q, fast_rate_constant_q;
  logic [15:0] current_channel_word, voltage_channel_word, current_word_q, voltage_word_q;
  logic [4:0]  current_gain_amp_q;
  logic [4:0]  gain_exp [4] = '{5'h01, 5'h02, 5'h08, 5'h10};
  int          failures, checked, n;
  mpmc_pin_mode mpmc_pin_mode_inst (.*);
  mpmc_host_model mpmc_host_model_inst (
    .core_clk (core_clk),
    .clr_req  (clr_req),
    .entry_req(entry_req),
    .code     (code),
    .f_sel    (f_sel),
    .clear_n  (chip_clear_n),
    .sck      (freq_range_sel_2),
    .sdi      (freq_range_sel_1),
    .cs_n     (freq_range_sel_0)
  );
  always #20 core_clk = !core_clk;
  task automatic tick(input int k);
    repeat (k) @(posedge core_clk);
  endtask
  task automatic chk(input string s, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic end_sim;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task automatic t_straps;
    for (int v = 0; v < 8; v++) begin
      tick(1);
      offset_filter_ctrl <= v[2];
      {gain_sel_hi, gain_sel_lo} <= v[1:0];
      f_sel <= 3'(v) ^ 3'h5;
      tick(2);
      #1;
      chk("filter_en", 16'(offset_filter_en_q), 16'(v[2]));
      chk("gain", 16'(current_gain_amp_q), 16'(gain_exp[v[1:0]]));
      chk("slow_const", 16'(slow_rate_constant_q), 16'(3'(v) ^ 3'h5));
      chk("fast_const", 16'(fast_rate_constant_q), 16'(3'(v) ^ 3'h5));
    end
    $display("straps done");
  endtask
  task automatic t_pulses;
    for (int v = 1; v < 8; v = v * 2) begin
      tick(1);
      {slow_pulse_a, slow_pulse_b, fast_pulse} <= 3'(v);
      tick(1);
      #1;
      chk("pulses", 16'({counter_pulse_a, counter_pulse_b, calib_pulse_out}), 16'(v));
    end
    $display("pulses done");
  endtask
  task automatic t_neg;
    tick(1);
    power_negative <= 1'b1;
    fast_pulse <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      tick(1);
      fast_pulse <= 1'b1;
      tick(3);
      #1;
      chk("neg_flag", 16'(negative_power_flag), 16'(1 - k));
      tick(1);
      power_negative <= 1'b0;
      fast_pulse <= 1'b0;
      tick(4);
      #1;
      chk("neg_hold", 16'(negative_power_flag), 16'(1 - k));
    end
    $display("negative flag done");
  endtask
  task automatic t_clear;
    tick(1);
    current_channel_word <= 16'h1234;
    voltage_channel_word <= 16'hABCD;
    tick(1);
    #1;
    chk("cur_word", current_word_q, 16'h1234);
    tick(1);
    clr_req <= 1'b1;
    tick(2);
    #1;
    chk("conv_reset", 16'(conv_reset_q), 16'h0001);
    chk("cur_zero", current_word_q, 16'h0000);
    chk("volt_zero", voltage_word_q, 16'h0000);
    chk("gain_rst", 16'(current_gain_amp_q), 16'h0001);
    chk("filter_rst", 16'(offset_filter_en_q), 16'h0000);
    tick(1);
    clr_req <= 1'b0;
    tick(2);
    #1;
    chk("conv_run", 16'(conv_reset_q), 16'h0000);
    chk("volt_word", voltage_word_q, 16'hABCD);
    $display("clear done");
  endtask
  task automatic t_entry;
    for (int k = 0; k < 2; k++) begin
      tick(1);
      f_sel <= 3'h0;
      code <= k ? mpmc_pkg::ENTRY_CODE : 4'h5;
      entry_req <= 1'b1;
      tick(1);
      entry_req <= 1'b0;
      n = 0;
      while (serial_mode_q !== 1'b1 && n < 30) begin
        tick(1);
        #1;
        n++;
      end
      chk("serial_mode", 16'(serial_mode_q), 16'(k));
    end
    tick(1);
    f_sel <= 3'h7;
    tick(3);
    #1;
    chk("frozen", 16'({slow_rate_constant_q, fast_rate_constant_q}), 16'h0000);
    $display("entry done");
  endtask
  task automatic t_sdo;
    logic [31:0] w;
    w = {current_channel_word, voltage_channel_word};
    tick(1);
    f_sel <= 3'h1;
    tick(4);
    f_sel <= 3'h0;
    for (int i = 31; i >= 0; i--) begin
      tick(4);
      #1;
      chk("sdo", 16'(negative_power_flag), 16'(w[i]));
      tick(1);
      f_sel <= 3'h4;
      tick(2);
      f_sel <= 3'h0;
    end
    $display("serial out done");
  endtask
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    {clr_req, entry_req, code, f_sel} = 9'h000;
    {offset_filter_ctrl, gain_sel_hi, gain_sel_lo, power_negative} = 4'h0;
    {slow_pulse_a, slow_pulse_b, fast_pulse} = 3'h0;
    current_channel_word = 16'h0000;
    voltage_channel_word = 16'h0000;
    tick(10);
    srst <= 1'b0;
    tick(15);
    t_straps;
    t_pulses;
    t_neg;
    t_clear;
    t_entry;
    t_sdo;
    end_sim;
  end
endmodule
`default_nettype wire
